// File: include/rstc_pkg.sv
`default_nettype none
package rstc_pkg;
  // Register byte offsets on the plain register port
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] CFGW_OFS = 4'h8;
  localparam logic [3:0] CFGS_OFS = 4'hC;
  // Control register fields
  localparam int CTRL_SW_HARD_BIT = 0;
  localparam int CTRL_SW_SOFT_BIT = 1;
  localparam int CTRL_WDOG_EN_BIT = 2;
  localparam logic CTRL_WDOG_EN_RST = 1'b1;
  // Status register cause bits
  localparam int CAUSE_W = 9;
  localparam int ST_POR = 0;
  localparam int ST_EXT_HARD = 1;
  localparam int ST_EXT_SOFT = 2;
  localparam int ST_TAP_HOST = 3;
  localparam int ST_WDOG = 4;
  localparam int ST_SERIAL = 5;
  localparam int ST_SW_HARD = 6;
  localparam int ST_SW_SOFT = 7;
  localparam int ST_JTAG_BND = 8;
  localparam logic [CAUSE_W-1:0] STAT_RST = 9'h000;
  // Configuration word and source widths and reset values
  localparam int CFGW_W = 17;
  localparam int CFGS_W = 3;
  localparam logic [CFGW_W-1:0] CFGW_RST = 17'h00000;
  localparam logic [CFGS_W-1:0] CFGS_RST = 3'h0;
  // Timing counts in reference clock cycles
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] HARD_HOLD_CYC = 8'h40;
  localparam logic [CNT_W-1:0] SOFT_HOLD_CYC = 8'h20;
  localparam logic [CNT_W-1:0] SOFT_AFTER_HARD_CYC = 8'h10;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PWR = 3'b001,
    ST_HARD = 3'b010,
    ST_TAIL = 3'b011,
    ST_SOFT = 3'b100
  } rstc_state_t;
endpackage : rstc_pkg
`default_nettype wire

// File: hw/rstc_ctrl.sv
// Implementation choices: strobed register access and the placing of the registers.
`default_nettype none
module rstc_ctrl (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_power_on_reset_n,
  input wire logic i_hard_reset_n,
  input wire logic i_soft_reset_n,
  input wire logic i_tap_host_reset,
  input wire logic i_jtag_bnd_active,
  input wire logic i_jtag_bnd_drive_soft,
  input wire logic i_wdog_expire,
  input wire logic i_serial_hard_req,
  input wire logic [16:0] i_cfg_pins,
  input wire logic [2:0] i_cfg_src_pins,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_hard_reset_n_o,
  output logic o_hard_reset_n_oe,
  output logic o_soft_reset_n_o,
  output logic o_soft_reset_n_oe,
  output logic o_pll_reset,
  output logic o_cfg_sample,
  output logic o_core_reset,
  output logic o_periph_reset,
  output logic o_subsys_full_reset,
  output logic o_subsys_part_reset,
  output logic o_wdog_event,
  output logic [16:0] o_cfg_word,
  output logic [2:0] o_cfg_src
);
  rstc_pkg::rstc_state_t state_q, state_d;
  logic [2:0] sync1_q, sync2_q;
  logic soft_prev_q;
  logic [rstc_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic soft_drv_q, soft_drv_d;
  logic wdog_en_q;
  logic [rstc_pkg::CAUSE_W-1:0] stat_q, cause_w;
  logic por_w, ext_hard_w, soft_fell_w, sw_hard_w, sw_soft_w;
  logic hard_req_w, soft_req_w, ctrl_wr_w;

  // Two-flop synchronisers for power-on, hard and soft pins
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
      soft_prev_q <= 1'b1;
    end
    else
    begin
      sync1_q <= {i_soft_reset_n, i_hard_reset_n, i_power_on_reset_n};
      sync2_q <= sync1_q;
      soft_prev_q <= sync2_q[2];
    end
  end

  // Source decode; external soft is taken on its falling edge only
  assign por_w = !sync2_q[0];
  assign ext_hard_w = !sync2_q[1];
  assign soft_fell_w = soft_prev_q && !sync2_q[2];
  assign ctrl_wr_w = i_wr && (i_addr == rstc_pkg::CTRL_OFS);
  assign sw_hard_w = ctrl_wr_w && i_wdata[rstc_pkg::CTRL_SW_HARD_BIT];
  assign sw_soft_w = ctrl_wr_w && i_wdata[rstc_pkg::CTRL_SW_SOFT_BIT];
  always_comb
  begin
    cause_w = '0;
    cause_w[rstc_pkg::ST_POR] = por_w;
    cause_w[rstc_pkg::ST_EXT_HARD] = ext_hard_w;
    cause_w[rstc_pkg::ST_WDOG] = i_wdog_expire && wdog_en_q;
    cause_w[rstc_pkg::ST_SERIAL] = i_serial_hard_req;
    cause_w[rstc_pkg::ST_SW_HARD] = sw_hard_w;
    cause_w[rstc_pkg::ST_EXT_SOFT] = soft_fell_w;
    cause_w[rstc_pkg::ST_TAP_HOST] = i_tap_host_reset;
    cause_w[rstc_pkg::ST_SW_SOFT] = sw_soft_w;
    cause_w[rstc_pkg::ST_JTAG_BND] = i_jtag_bnd_active;
  end
  assign hard_req_w = |cause_w[rstc_pkg::ST_SW_HARD:rstc_pkg::ST_WDOG]
    || ext_hard_w;
  assign soft_req_w = cause_w[rstc_pkg::ST_EXT_SOFT]
    || cause_w[rstc_pkg::ST_TAP_HOST] || cause_w[rstc_pkg::ST_SW_SOFT]
    || cause_w[rstc_pkg::ST_JTAG_BND];

  // Sequencer: power-on over hard over soft
  always_comb
  begin
    state_d = state_q;
    cnt_d = (cnt_q == '0) ? cnt_q : cnt_q - 1'b1;
    soft_drv_d = soft_drv_q;
    if (por_w)
    begin
      state_d = rstc_pkg::ST_PWR;
      cnt_d = rstc_pkg::HARD_HOLD_CYC;
    end
    else
    begin
      case (state_q)
        rstc_pkg::ST_IDLE:
        begin
          if (hard_req_w)
          begin
            state_d = rstc_pkg::ST_HARD;
            cnt_d = rstc_pkg::HARD_HOLD_CYC;
          end
          else if (soft_req_w)
          begin
            state_d = rstc_pkg::ST_SOFT;
            cnt_d = rstc_pkg::SOFT_HOLD_CYC;
            soft_drv_d = !i_jtag_bnd_active || i_jtag_bnd_drive_soft;
          end
        end
        rstc_pkg::ST_PWR:
        begin
          state_d = rstc_pkg::ST_HARD;
          cnt_d = rstc_pkg::HARD_HOLD_CYC;
        end
        rstc_pkg::ST_HARD:
        begin
          if (cnt_q == '0)
          begin
            state_d = rstc_pkg::ST_TAIL;
            cnt_d = rstc_pkg::SOFT_AFTER_HARD_CYC - 1'b1;
          end
        end
        rstc_pkg::ST_TAIL:
        begin
          if (cnt_q == '0)
            state_d = rstc_pkg::ST_IDLE;
        end
        rstc_pkg::ST_SOFT:
        begin
          if (hard_req_w)
          begin
            state_d = rstc_pkg::ST_HARD;
            cnt_d = rstc_pkg::HARD_HOLD_CYC;
          end
          else if (i_jtag_bnd_active)
            cnt_d = rstc_pkg::SOFT_HOLD_CYC;
          else if (cnt_q == '0)
            state_d = rstc_pkg::ST_IDLE;
        end
        default:
          state_d = rstc_pkg::ST_IDLE;
      endcase
    end
  end

  // State, counter and soft drive selection
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      state_q <= rstc_pkg::ST_IDLE;
      cnt_q <= '0;
      soft_drv_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      soft_drv_q <= soft_drv_d;
    end
  end

  // Reset actions registered from the current state
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      o_hard_reset_n_o <= 1'b0;
      o_hard_reset_n_oe <= 1'b0;
      o_soft_reset_n_o <= 1'b0;
      o_soft_reset_n_oe <= 1'b0;
      o_pll_reset <= 1'b0;
      o_cfg_sample <= 1'b0;
      o_core_reset <= 1'b0;
      o_periph_reset <= 1'b0;
      o_subsys_full_reset <= 1'b0;
      o_subsys_part_reset <= 1'b0;
    end
    else
    begin
      o_hard_reset_n_o <= 1'b0;
      o_soft_reset_n_o <= 1'b0;
      o_hard_reset_n_oe <= (state_q == rstc_pkg::ST_PWR)
        || (state_q == rstc_pkg::ST_HARD);
      o_soft_reset_n_oe <= (state_q == rstc_pkg::ST_PWR)
        || (state_q == rstc_pkg::ST_HARD) || (state_q == rstc_pkg::ST_TAIL)
        || (state_q == rstc_pkg::ST_SOFT && soft_drv_q);
      o_pll_reset <= (state_q == rstc_pkg::ST_PWR);
      o_cfg_sample <= (state_q == rstc_pkg::ST_PWR);
      o_core_reset <= (state_q != rstc_pkg::ST_IDLE);
      o_periph_reset <= (state_q != rstc_pkg::ST_IDLE);
      o_subsys_full_reset <= (state_q == rstc_pkg::ST_PWR)
        || (state_q == rstc_pkg::ST_HARD)
        || (state_q == rstc_pkg::ST_TAIL);
      o_subsys_part_reset <= (state_q == rstc_pkg::ST_SOFT);
    end
  end

  // Configuration word and source taken only during power-on
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      o_cfg_word <= rstc_pkg::CFGW_RST;
      o_cfg_src <= rstc_pkg::CFGS_RST;
    end
    else if (state_q == rstc_pkg::ST_PWR)
    begin
      o_cfg_word <= i_cfg_pins;
      o_cfg_src <= i_cfg_src_pins;
    end
  end

  // Cause capture on every sequence start; write one clears, set wins
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      stat_q <= rstc_pkg::STAT_RST;
    else if (state_d != rstc_pkg::ST_IDLE && (state_q == rstc_pkg::ST_IDLE
      || (state_d == rstc_pkg::ST_PWR && state_q != rstc_pkg::ST_PWR)
      || (state_q == rstc_pkg::ST_SOFT && state_d == rstc_pkg::ST_HARD)))
      stat_q <= cause_w;
    else if (i_wr && i_addr == rstc_pkg::STAT_OFS)
      stat_q <= stat_q & ~i_wdata[rstc_pkg::CAUSE_W-1:0];
  end

  // Watchdog enable bit and watchdog event pulse
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      wdog_en_q <= rstc_pkg::CTRL_WDOG_EN_RST;
      o_wdog_event <= 1'b0;
    end
    else
    begin
      if (ctrl_wr_w)
        wdog_en_q <= i_wdata[rstc_pkg::CTRL_WDOG_EN_BIT];
      o_wdog_event <= i_wdog_expire && wdog_en_q;
    end
  end

  // Read data, valid in the cycle after the read strobe
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      o_rdata <= '0;
    else if (i_rd)
    begin
      case (i_addr)
        rstc_pkg::CTRL_OFS:
          o_rdata <= {29'h0, wdog_en_q, 2'h0};
        rstc_pkg::STAT_OFS:
          o_rdata <= {23'h0, stat_q};
        rstc_pkg::CFGW_OFS:
          o_rdata <= {15'h0, o_cfg_word};
        rstc_pkg::CFGS_OFS:
          o_rdata <= {29'h0, o_cfg_src};
        default:
          o_rdata <= '0;
      endcase
    end
    else
      o_rdata <= '0;
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  por_drive_both_a: assert property (
    state_q == rstc_pkg::ST_PWR |=> o_hard_reset_n_oe && o_soft_reset_n_oe
      && o_pll_reset && o_core_reset)
    else $error("power-on does not drive both reset pins");
  cfg_por_only_a: assert property (
    state_q != rstc_pkg::ST_PWR |=> $stable(o_cfg_word)
      && $stable(o_cfg_src))
    else $error("configuration changed outside power-on");
  hard_soft_pair_a: assert property (
    o_hard_reset_n_oe |-> o_soft_reset_n_oe && !o_soft_reset_n_o)
    else $error("hard reset driven without soft reset");
  soft_tail_gap_a: assert property (
    $fell(o_hard_reset_n_oe) && !por_w |-> o_soft_reset_n_oe[*8] ##1
      o_soft_reset_n_oe[*8] ##1 !o_soft_reset_n_oe)
    else $error("soft release not 16 cycles after hard release");
  soft_busy_ignore_a: assert property (
    state_q == rstc_pkg::ST_HARD |=> state_q != rstc_pkg::ST_SOFT)
    else $error("soft reset taken while hard reset active");
  wdog_hard_start_a: assert property (
    state_q == rstc_pkg::ST_IDLE && !por_w && i_wdog_expire && wdog_en_q
      |=> state_q == rstc_pkg::ST_HARD && o_wdog_event)
    else $error("watchdog expiry did not start hard reset");
  serial_hard_start_a: assert property (
    state_q == rstc_pkg::ST_IDLE && !por_w && i_serial_hard_req
      |=> state_q == rstc_pkg::ST_HARD ##1 o_hard_reset_n_oe)
    else $error("serial request did not start hard reset");
  sw_hard_start_a: assert property (
    state_q == rstc_pkg::ST_IDLE && !por_w && sw_hard_w
      |=> state_q == rstc_pkg::ST_HARD ##1 o_hard_reset_n_oe)
    else $error("software hard request ignored");
  sw_soft_start_a: assert property (
    state_q == rstc_pkg::ST_IDLE && !por_w && !hard_req_w && sw_soft_w
      |=> state_q == rstc_pkg::ST_SOFT ##1 o_soft_reset_n_oe
      && !o_hard_reset_n_oe)
    else $error("software soft request ignored");
  tap_soft_start_a: assert property (
    state_q == rstc_pkg::ST_IDLE && !por_w && !hard_req_w && i_tap_host_reset
      |=> state_q == rstc_pkg::ST_SOFT)
    else $error("tap host reset did not start soft reset");
  stat_cause_a: assert property (
    state_q == rstc_pkg::ST_IDLE && !por_w && sw_hard_w
      |=> stat_q[rstc_pkg::ST_SW_HARD])
    else $error("status misses software hard cause");
  pll_por_only_a: assert property (
    o_pll_reset |-> $past(state_q) == rstc_pkg::ST_PWR)
    else $error("pll reset outside power-on");
  periph_all_a: assert property (
    state_q != rstc_pkg::ST_IDLE |=> o_periph_reset)
    else $error("peripherals not reset during a reset");
  cover_por_c: cover property ($fell(o_pll_reset));
  cover_soft_c: cover property ($rose(o_subsys_part_reset));
  cover_tail_c: cover property ($fell(o_hard_reset_n_oe));
endmodule : rstc_ctrl
`default_nettype wire

// File: bench/rstc_board.sv
`default_nettype none
// Board reset logic: supervisor for power-on and open-drain pin pull-ups
module rstc_board (
  input wire logic i_core_clk,
  input wire logic i_por_req,
  input wire logic i_hard_pull,
  input wire logic i_soft_pull,
  input wire logic i_hard_oe,
  input wire logic i_hard_o,
  input wire logic i_soft_oe,
  input wire logic i_soft_o,
  output logic o_power_on_reset_n,
  output logic o_hard_reset_n,
  output logic o_soft_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hold_q = 8'h20;
  // Keeps power-on low for 32 cycles after the last request
  always_ff @(posedge i_core_clk)
  begin
    if (i_por_req)
      hold_q <= 8'h00;
    else if (hold_q < 8'h20)
      hold_q <= hold_q + 8'h01;
  end
  assign o_power_on_reset_n = !(i_por_req || hold_q < 8'h20);
  // Pull-ups: any party may only pull low, nobody drives high
  assign o_hard_reset_n = !i_hard_pull && !(i_hard_oe && !i_hard_o);
  assign o_soft_reset_n = !i_soft_pull && !(i_soft_oe && !i_soft_o);
endmodule : rstc_board
`default_nettype wire

// File: bench/rstc_ctrl_tb.sv
`default_nettype none
module rstc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
  typedef struct {logic [3:0] addr; logic [31:0] exp;} rstc_row_t;
  rstc_row_t rows [5] = '{'{4'h0, 32'h4}, '{4'h4, 32'h0}, '{4'h8, 32'h0},
    '{4'hC, 32'h0}, '{4'h2, 32'h0}};
  logic i_core_clk = 1'b0, i_rst_b = 1'b0, por_req = 1'b0;
  logic hard_pull = 1'b0, soft_pull = 1'b0, drv_soft = 1'b0;
  logic i_wr = 1'b0, i_rd = 1'b0;
  logic [3:0] trig = 4'h0, i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata, d;
  logic [16:0] i_cfg_pins = 17'h00000, o_cfg_word, cfgw_exp;
  logic [2:0] i_cfg_src_pins = 3'h0, o_cfg_src, cfgs_exp;
  logic por_n, hard_n, soft_n, o_hard_reset_n_o, o_hard_reset_n_oe;
  logic o_soft_reset_n_o, o_soft_reset_n_oe, o_pll_reset, o_cfg_sample;
  logic o_core_reset, o_periph_reset, o_subsys_full_reset;
  logic o_subsys_part_reset, o_wdog_event;
  int n_errors = 0, n_compared = 0, cyc = 0, ev_cnt = 0, n, ev0;
  always #4 i_core_clk = !i_core_clk;
  rstc_ctrl i_rstc_ctrl (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_power_on_reset_n(por_n), .i_hard_reset_n(hard_n),
    .i_soft_reset_n(soft_n), .i_tap_host_reset(trig[2]),
    .i_jtag_bnd_active(trig[3]), .i_jtag_bnd_drive_soft(drv_soft),
    .i_wdog_expire(trig[0]), .i_serial_hard_req(trig[1]),
    .i_cfg_pins(i_cfg_pins), .i_cfg_src_pins(i_cfg_src_pins),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_hard_reset_n_o(o_hard_reset_n_o),
    .o_hard_reset_n_oe(o_hard_reset_n_oe),
    .o_soft_reset_n_o(o_soft_reset_n_o),
    .o_soft_reset_n_oe(o_soft_reset_n_oe), .o_pll_reset(o_pll_reset),
    .o_cfg_sample(o_cfg_sample), .o_core_reset(o_core_reset),
    .o_periph_reset(o_periph_reset),
    .o_subsys_full_reset(o_subsys_full_reset),
    .o_subsys_part_reset(o_subsys_part_reset),
    .o_wdog_event(o_wdog_event), .o_cfg_word(o_cfg_word),
    .o_cfg_src(o_cfg_src));
  rstc_board i_rstc_board (.i_core_clk(i_core_clk), .i_por_req(por_req),
    .i_hard_pull(hard_pull), .i_soft_pull(soft_pull),
    .i_hard_oe(o_hard_reset_n_oe), .i_hard_o(o_hard_reset_n_o),
    .i_soft_oe(o_soft_reset_n_oe), .i_soft_o(o_soft_reset_n_o),
    .o_power_on_reset_n(por_n), .o_hard_reset_n(hard_n),
    .o_soft_reset_n(soft_n));
  // Verdict and end of run
  task end_of_test;
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // Cycle ceiling against hangs, and watchdog event counting
  always @(posedge i_core_clk)
  begin
    cyc++;
    ev_cnt += (o_wdog_event === 1'b1);
    if (cyc == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  // Register bus cycles
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd
  // One-cycle pulse on a trigger input
  task pulse(input int k);
    @(posedge i_core_clk);
    trig[k] <= 1'b1;
    @(posedge i_core_clk);
    trig[k] <= 1'b0;
  endtask : pulse
  // Follows one sequence: actions, release timing, cause, kept config
  task seq(input logic p, input logic h, input logic s, input logic [8:0] st);
    while (o_core_reset !== 1'b1)
    begin
      @(posedge i_core_clk);
      #1;
    end
    repeat (2) @(posedge i_core_clk);
    #1 `CHK(o_pll_reset, p)
    `CHK(o_cfg_sample, p)
    `CHK(o_hard_reset_n_oe, h)
    `CHK(o_soft_reset_n_oe, s)
    `CHK(o_periph_reset, 1'b1)
    `CHK(o_subsys_full_reset, h)
    `CHK(o_subsys_part_reset, !h)
    `CHK({o_hard_reset_n_o, o_soft_reset_n_o}, 2'h0)
    `CHK({hard_n, soft_n}, {!h, !s})
    while (o_hard_reset_n_oe === 1'b1) begin @(posedge i_core_clk); #1; end
    n = 0;
    while (o_core_reset === 1'b1)
    begin
      @(posedge i_core_clk);
      #1 n++;
    end
    if (h)
      `CHK(n, 16)
    rd(4'h4, d);
    `CHK(d[8:0], st)
    wr(4'h4, 32'h1FF);
    `CHK(o_cfg_word, cfgw_exp)
    `CHK(o_cfg_src, cfgs_exp)
  endtask : seq
  // Register defaults in a loop, then the reset sources by hand
  initial
  begin
    repeat (4) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    @(posedge i_core_clk);
    #1 `CHK({o_hard_reset_n_oe, o_soft_reset_n_oe, o_core_reset}, 3'h0)
    foreach (rows[k])
    begin
      rd(rows[k].addr, d);
      `CHK(d, rows[k].exp)
    end
    i_cfg_pins <= 17'h1A5A5;
    i_cfg_src_pins <= 3'h5;
    cfgw_exp = 17'h1A5A5;
    cfgs_exp = 3'h5;
    por_req <= 1'b1;
    @(posedge i_core_clk);
    por_req <= 1'b0;
    seq(1'b1, 1'b1, 1'b1, 9'h001);
    i_cfg_pins <= 17'h0F0F0;
    i_cfg_src_pins <= 3'h2;
    wr(4'h0, 32'h1);
    seq(1'b0, 1'b1, 1'b1, 9'h040);
    wr(4'h0, 32'h6);
    seq(1'b0, 1'b0, 1'b1, 9'h080);
    ev0 = ev_cnt;
    pulse(0);
    seq(1'b0, 1'b1, 1'b1, 9'h010);
    `CHK(ev_cnt - ev0, 1)
    wr(4'h0, 32'h0);
    ev0 = ev_cnt;
    pulse(0);
    repeat (6) @(posedge i_core_clk);
    #1 `CHK({o_core_reset, 1'b0}, 2'h0)
    `CHK(ev_cnt - ev0, 0)
    wr(4'h0, 32'h4);
    pulse(1);
    seq(1'b0, 1'b1, 1'b1, 9'h020);
    pulse(2);
    seq(1'b0, 1'b0, 1'b1, 9'h008);
    drv_soft <= 1'b1;
    pulse(3);
    seq(1'b0, 1'b0, 1'b1, 9'h100);
    drv_soft <= 1'b0;
    pulse(3);
    seq(1'b0, 1'b0, 1'b0, 9'h100);
    // Boundary instruction held long keeps the soft sequence alive
    trig[3] <= 1'b1;
    repeat (50) @(posedge i_core_clk);
    trig[3] <= 1'b0;
    #1 `CHK(o_subsys_part_reset, 1'b1)
    seq(1'b0, 1'b0, 1'b0, 9'h100);
    hard_pull <= 1'b1;
    repeat (8) @(posedge i_core_clk);
    hard_pull <= 1'b0;
    seq(1'b0, 1'b1, 1'b1, 9'h002);
    soft_pull <= 1'b1;
    repeat (8) @(posedge i_core_clk);
    soft_pull <= 1'b0;
    seq(1'b0, 1'b0, 1'b1, 9'h004);
    wr(4'h0, 32'h5);
    soft_pull <= 1'b1;
    seq(1'b0, 1'b1, 1'b1, 9'h040);
    repeat (5) @(posedge i_core_clk);
    soft_pull <= 1'b0;
    repeat (10) @(posedge i_core_clk);
    #1 `CHK(o_core_reset, 1'b0)
    // Block reset in the middle of a hard sequence
    wr(4'h0, 32'h5);
    repeat (6) @(posedge i_core_clk);
    i_rst_b <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    #1 `CHK({o_hard_reset_n_oe, o_core_reset}, 2'h0)
    `CHK(o_cfg_word, rstc_pkg::CFGW_RST)
    repeat (3) @(posedge i_core_clk);
    #1 `CHK({o_soft_reset_n_oe, o_periph_reset}, 2'h0)
    rd(4'h4, d);
    `CHK(d[8:0], rstc_pkg::STAT_RST)
    end_of_test();
  end
endmodule : rstc_ctrl_tb
`default_nettype wire
